// ### pkg/lmtc_pkg.sv
// lmtc_pkg: constants and types of the legacy mode trap control block
// assumes a 32-bit AXI4-Lite register bus and a core on the same clock
package lmtc_pkg;
	// register byte offsets
	localparam int         AXI_AW     = 5;
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_STAT   = 5'h04;
	localparam logic [4:0] OFS_CAUSE  = 5'h08;
	localparam logic [4:0] OFS_COUNT  = 5'h0c;
	// control fields and reset value
	localparam int         CTRL_PE    = 0;
	localparam int         CTRL_PG    = 1;
	localparam int         CTRL_W     = 2;
	localparam logic [1:0] CTRL_RST   = 2'h0;
	// status fields
	localparam int         STAT_VM    = 0;
	localparam int         STAT_PE    = 1;
	localparam int         STAT_IF    = 2;
	localparam int         STAT_IO_PRIVILEGE_LEVEL  = 3;
	localparam int         STAT_W     = 5;
	// flags image layout pushed at handler entry
	localparam int         IMG_IF     = 0;
	localparam int         IMG_IO_PRIVILEGE_LEVEL   = 1;
	localparam int         IMG_VM     = 3;
	localparam int         IMG_W      = 4;
	// flag reset values and limits
	localparam logic       IF_RST     = 1'b0;
	localparam logic [1:0] IO_PRIVILEGE_LEVEL_RST   = 2'h0;
	localparam logic [1:0] IO_PRIVILEGE_LEVEL_TOP   = 2'h3;
	// exception vectors
	localparam logic [7:0] VEC_GP     = 8'h0d;
	localparam logic [7:0] VEC_PF     = 8'h0e;
	// legacy linear address width, one megabyte
	localparam int         V86_AW     = 20;
	// bus responses
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_REAL = 2'h0,
		MODE_PROT = 2'h1,
		MODE_VM   = 2'h2
	} lmtc_mode_type;

	typedef enum logic [2:0] {
		OP_OTHER = 3'h0,
		OP_CLI   = 3'h1,
		OP_STI   = 3'h2,
		OP_INT   = 3'h3,
		OP_IO    = 3'h4
	} lmtc_op_type;

	typedef enum logic [2:0] {
		CS_NONE  = 3'h0,
		CS_IFOP  = 3'h1,
		CS_SWINT = 3'h2,
		CS_IO    = 3'h3,
		CS_PG_NP = 3'h4,
		CS_PG_RO = 3'h5
	} lmtc_cause_type;
endpackage

// ### hw/lmtc_pgchk.sv
// lmtc_pgchk: legacy address mapping and page attribute check
// assumes page attributes arrive from the core's translation lookup
module lmtc_pgchk (
	input  wire logic                  pg_en,
	input  wire logic                  vm,
	input  wire logic                  acc_valid,
	input  wire logic                  acc_write,
	input  wire logic [15:0]           acc_seg,
	input  wire logic [15:0]           acc_off,
	input  wire logic                  pte_present,
	input  wire logic                  pte_writable,
	output logic                       fault,
	output lmtc_pkg::lmtc_cause_type   cause,
	output logic [31:0]                lin
);
	logic [lmtc_pkg::V86_AW-1:0] lin20;

	// one megabyte confine
	// the carry out of bit 19 is dropped, as on the legacy part
	assign lin20 = {acc_seg, 4'h0} + {4'h0, acc_off};
	assign lin = vm ? {12'h000, lin20} : {acc_seg, acc_off};

	always_comb begin
		fault = 1'b0;
		cause = lmtc_pkg::CS_NONE;
		if (acc_valid && pg_en) begin
			if (!pte_present) begin
				fault = 1'b1;
				cause = lmtc_pkg::CS_PG_NP;
			end else if (acc_write && !pte_writable) begin
				fault = 1'b1;
				cause = lmtc_pkg::CS_PG_RO;
			end
		end
	end
endmodule

// ### hw/lmtc_axil.sv
// lmtc_axil: AXI4-Lite slave holding the control register
// assumes one outstanding write and one outstanding read per master
module lmtc_axil (
	input  wire logic                         mclk,
	input  wire logic                         nrst,
	input  wire logic [lmtc_pkg::AXI_AW-1:0]  awaddr,
	input  wire logic                         awvalid,
	output logic                              awready,
	input  wire logic [31:0]                  wdata,
	input  wire logic [3:0]                   wstrb,
	input  wire logic                         wvalid,
	output logic                              wready,
	output logic [1:0]                        bresp,
	output logic                              bvalid,
	input  wire logic                         bready,
	input  wire logic [lmtc_pkg::AXI_AW-1:0]  araddr,
	input  wire logic                         arvalid,
	output logic                              arready,
	output logic [31:0]                       rdata,
	output logic [1:0]                        rresp,
	output logic                              rvalid,
	input  wire logic                         rready,
	input  wire logic [lmtc_pkg::STAT_W-1:0]  stat_in,
	input  wire logic [2:0]                   cause_in,
	input  wire logic [31:0]                  count_in,
	output logic [lmtc_pkg::CTRL_W-1:0]       ctrl_q
);
	logic                        aw_hold_q;
	logic                        w_hold_q;
	logic [lmtc_pkg::AXI_AW-1:0] awaddr_q;
	logic [31:0]                 wdata_q;
	logic                        wstrb0_q;
	logic                        do_wr;
	logic [31:0]                 rd_mux;
	logic                        rd_hit;

	assign do_wr = aw_hold_q && w_hold_q && !bvalid;

	// address and data are taken in either order, ready drops until the response
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awready   <= 1'b1;
			wready    <= 1'b1;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0000_0000;
			wstrb0_q  <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_hold_q <= 1'b1;
				awready   <= 1'b0;
				awaddr_q  <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold_q <= 1'b1;
				wready   <= 1'b0;
				wdata_q  <= wdata;
				wstrb0_q <= wstrb[0];
			end
			if (do_wr) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
			end
			if (bvalid && bready) begin
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bvalid <= 1'b0;
			bresp  <= lmtc_pkg::RESP_OKAY;
			ctrl_q <= lmtc_pkg::CTRL_RST;
		end else begin
			if (do_wr) begin
				bvalid <= 1'b1;
				bresp  <= (awaddr_q[4:2] > 3'h3) ? lmtc_pkg::RESP_SLVERR : lmtc_pkg::RESP_OKAY;
				if (awaddr_q[4:2] == lmtc_pkg::OFS_CTRL[4:2] && wstrb0_q) begin
					ctrl_q <= wdata_q[lmtc_pkg::CTRL_W-1:0];
				end
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		case (araddr[4:2])
			lmtc_pkg::OFS_CTRL[4:2]:  rd_mux = {30'h0, ctrl_q};
			lmtc_pkg::OFS_STAT[4:2]:  rd_mux = {27'h0, stat_in};
			lmtc_pkg::OFS_CAUSE[4:2]: rd_mux = {29'h0, cause_in};
			lmtc_pkg::OFS_COUNT[4:2]: rd_mux = count_in;
			default: begin
				rd_mux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= lmtc_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_mux;
			rresp   <= rd_hit ? lmtc_pkg::RESP_OKAY : lmtc_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end
endmodule

// ### hw/lmtc_top.sv
// lmtc_top: mode control and legacy task trapping of a 32-bit core
// assumes all core strobes are one-cycle pulses on mclk
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
module lmtc_top #(
	parameter int COUNT_W = 16
) (
	input  wire logic                         mclk,
	input  wire logic                         nrst,
	input  wire logic [lmtc_pkg::AXI_AW-1:0]  awaddr,
	input  wire logic                         awvalid,
	output logic                              awready,
	input  wire logic [31:0]                  wdata,
	input  wire logic [3:0]                   wstrb,
	input  wire logic                         wvalid,
	output logic                              wready,
	output logic [1:0]                        bresp,
	output logic                              bvalid,
	input  wire logic                         bready,
	input  wire logic [lmtc_pkg::AXI_AW-1:0]  araddr,
	input  wire logic                         arvalid,
	output logic                              arready,
	output logic [31:0]                       rdata,
	output logic [1:0]                        rresp,
	output logic                              rvalid,
	input  wire logic                         rready,
	input  wire logic                         task_load,
	input  wire logic                         task_vm,
	input  wire logic [1:0]                   task_io_privilege_level,
	input  wire logic                         task_if,
	input  wire logic                         exc_req,
	input  wire logic                         intr_req,
	input  wire logic                         gate_trap,
	input  wire logic                         hret,
	input  wire logic                         ret_vm,
	input  wire logic [1:0]                   ret_io_privilege_level,
	input  wire logic                         ret_if,
	input  wire logic                         op_valid,
	input  wire lmtc_pkg::lmtc_op_type        op_class,
	input  wire logic                         acc_valid,
	input  wire logic                         acc_write,
	input  wire logic [15:0]                  acc_seg,
	input  wire logic [15:0]                  acc_off,
	input  wire logic                         pte_present,
	input  wire logic                         pte_writable,
	output logic                              vm_mode,
	output logic                              prot_mode,
	output logic                              if_flag,
	output logic [1:0]                        io_privilege_level,
	output logic                              fetch_ok,
	output logic                              hdl_entry,
	output logic                              trap,
	output logic [7:0]                        trap_vec,
	output lmtc_pkg::lmtc_cause_type          trap_cause,
	output logic                              img_valid,
	output logic [lmtc_pkg::IMG_W-1:0]        img_flags,
	output logic                              lin_valid,
	output logic [31:0]                       lin_addr
);
	if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count
		$error("lmtc_top: COUNT_W must lie in 1..32");
	end

	lmtc_pkg::lmtc_mode_type     mode_q;
	lmtc_pkg::lmtc_mode_type     mode_d;
	logic [lmtc_pkg::CTRL_W-1:0] ctrl;
	logic                        pe;
	logic                        pg_en;
	logic                        in_vm;
	logic                        in_pm;
	logic                        op_trap;
	lmtc_pkg::lmtc_cause_type    op_cause;
	logic                        pg_fault;
	lmtc_pkg::lmtc_cause_type    pg_cause;
	logic [31:0]                 lin;
	logic                        trap_now;
	logic                        enter;
	logic                        if_q;
	logic [1:0]                  io_privilege_level_q;
	lmtc_pkg::lmtc_cause_type    last_cause_q;
	logic [COUNT_W-1:0]          count_q;
	logic [lmtc_pkg::STAT_W-1:0] stat;
	logic [31:0]                 count_ext;

	assign pe    = ctrl[lmtc_pkg::CTRL_PE];
	assign pg_en = ctrl[lmtc_pkg::CTRL_PG];
	assign in_vm = (mode_q == lmtc_pkg::MODE_VM);
	assign in_pm = (mode_q != lmtc_pkg::MODE_REAL);

	lmtc_axil u_axil (
		.mclk     (mclk),
		.nrst     (nrst),
		.awaddr   (awaddr),
		.awvalid  (awvalid),
		.awready  (awready),
		.wdata    (wdata),
		.wstrb    (wstrb),
		.wvalid   (wvalid),
		.wready   (wready),
		.bresp    (bresp),
		.bvalid   (bvalid),
		.bready   (bready),
		.araddr   (araddr),
		.arvalid  (arvalid),
		.arready  (arready),
		.rdata    (rdata),
		.rresp    (rresp),
		.rvalid   (rvalid),
		.rready   (rready),
		.stat_in  (stat),
		.cause_in (last_cause_q),
		.count_in (count_ext),
		.ctrl_q   (ctrl)
	);

	lmtc_pgchk u_pgchk (
		.pg_en        (pg_en),
		.vm           (in_vm),
		.acc_valid    (acc_valid),
		.acc_write    (acc_write),
		.acc_seg      (acc_seg),
		.acc_off      (acc_off),
		.pte_present  (pte_present),
		.pte_writable (pte_writable),
		.fault        (pg_fault),
		.cause        (pg_cause),
		.lin          (lin)
	);

	assign stat = {io_privilege_level_q, if_q, in_pm, in_vm};
	assign count_ext = 32'(count_q);

	// sensitive instructions of a virtual task become exceptions
	always_comb begin
		op_trap  = 1'b0;
		op_cause = lmtc_pkg::CS_NONE;
		if (op_valid && in_vm) begin
			case (op_class)
				lmtc_pkg::OP_CLI, lmtc_pkg::OP_STI: begin
					op_trap  = 1'b1;
					op_cause = lmtc_pkg::CS_IFOP;
				end
				lmtc_pkg::OP_INT: begin
					op_trap  = 1'b1;
					op_cause = lmtc_pkg::CS_SWINT;
				end
				lmtc_pkg::OP_IO: begin
					op_trap  = (io_privilege_level_q < lmtc_pkg::IO_PRIVILEGE_LEVEL_TOP);
					op_cause = op_trap ? lmtc_pkg::CS_IO : lmtc_pkg::CS_NONE;
				end
				default: begin
					op_trap  = 1'b0;
					op_cause = lmtc_pkg::CS_NONE;
				end
			endcase
		end
	end

	assign trap_now = op_trap || pg_fault;
	assign enter    = trap_now || exc_req || intr_req;

	// entry beats task load beats return when they meet in one cycle
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			lmtc_pkg::MODE_REAL: begin
				if (pe) begin
					mode_d = lmtc_pkg::MODE_PROT;
				end
			end
			lmtc_pkg::MODE_PROT, lmtc_pkg::MODE_VM: begin
				if (!pe) begin
					mode_d = lmtc_pkg::MODE_REAL;
				end else if (enter) begin
					mode_d = lmtc_pkg::MODE_PROT;
				end else if (task_load && task_vm) begin
					mode_d = lmtc_pkg::MODE_VM;
				end else if (task_load) begin
					mode_d = lmtc_pkg::MODE_PROT;
				end else if (hret) begin
					mode_d = ret_vm ? lmtc_pkg::MODE_VM : lmtc_pkg::MODE_PROT;
				end
			end
			default: mode_d = lmtc_pkg::MODE_REAL;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode_q    <= lmtc_pkg::MODE_REAL;
			vm_mode   <= 1'b0;
			prot_mode <= 1'b0;
		end else begin
			mode_q    <= mode_d;
			vm_mode   <= (mode_d == lmtc_pkg::MODE_VM);
			prot_mode <= (mode_d != lmtc_pkg::MODE_REAL);
		end
	end

	// fetch held on switch
	// the core may not fetch in the cycle the new mode first shows
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fetch_ok <= 1'b0;
		end else begin
			fetch_ok <= !(enter || task_load || hret || mode_d != mode_q);
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			if_q   <= lmtc_pkg::IF_RST;
			io_privilege_level_q <= lmtc_pkg::IO_PRIVILEGE_LEVEL_RST;
		end else if (enter) begin
			if (!gate_trap) begin
				if_q <= 1'b0;
			end
		end else if (task_load && in_pm) begin
			if_q   <= task_if;
			io_privilege_level_q <= task_io_privilege_level;
		end else if (hret) begin
			if_q   <= ret_if;
			io_privilege_level_q <= ret_io_privilege_level;
		end else if (op_valid && !in_vm && op_class == lmtc_pkg::OP_CLI) begin
			if_q <= 1'b0;
		end else if (op_valid && !in_vm && op_class == lmtc_pkg::OP_STI) begin
			if_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			if_flag <= lmtc_pkg::IF_RST;
			io_privilege_level    <= lmtc_pkg::IO_PRIVILEGE_LEVEL_RST;
		end else begin
			if_flag <= if_q;
			io_privilege_level    <= io_privilege_level_q;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			img_valid <= 1'b0;
			img_flags <= '0;
			hdl_entry <= 1'b0;
		end else begin
			img_valid <= enter;
			hdl_entry <= enter;
			if (enter) begin
				img_flags <= {in_vm, io_privilege_level_q, if_q};
			end
		end
	end

	// page faults outrank instruction traps in the reported cause
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			trap         <= 1'b0;
			trap_vec     <= lmtc_pkg::VEC_GP;
			trap_cause   <= lmtc_pkg::CS_NONE;
			last_cause_q <= lmtc_pkg::CS_NONE;
			count_q      <= '0;
		end else begin
			trap <= trap_now;
			if (trap_now) begin
				trap_vec     <= pg_fault ? lmtc_pkg::VEC_PF : lmtc_pkg::VEC_GP;
				trap_cause   <= pg_fault ? pg_cause : op_cause;
				last_cause_q <= pg_fault ? pg_cause : op_cause;
				count_q      <= count_q + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lin_valid <= 1'b0;
			lin_addr  <= 32'h0000_0000;
		end else begin
			lin_valid <= acc_valid && !pg_fault;
			if (acc_valid) begin
				lin_addr <= lin;
			end
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence vm_enter_s;
		pe && in_vm && enter;
	endsequence

	sequence vm_return_s;
		pe && mode_q == lmtc_pkg::MODE_PROT && hret && ret_vm && !enter && !task_load;
	endsequence

	property task_switch_p(logic vmf, lmtc_pkg::lmtc_mode_type m);
		pe && in_pm && !enter && task_load && task_vm == vmf |=> mode_q == m && vm_mode == vmf;
	endproperty

	real_reset_a: assert property (!pe |=> mode_q == lmtc_pkg::MODE_REAL && !prot_mode)
		else $error("mode not real while protection is off");

	vm_enter_a: assert property (task_switch_p(1'b1, lmtc_pkg::MODE_VM))
		else $error("task load with flag set did not enter legacy mode");

	vm_leave_a: assert property (task_switch_p(1'b0, lmtc_pkg::MODE_PROT))
		else $error("task load with flag clear did not leave legacy mode");

	entry_exit_a: assert property (vm_enter_s |=> !vm_mode && prot_mode && !fetch_ok)
		else $error("handler entry did not leave legacy mode");

	vm_resume_a: assert property (vm_return_s |=> vm_mode && mode_q == lmtc_pkg::MODE_VM)
		else $error("return did not resume legacy mode");

	img_save_a: assert property (vm_enter_s |=> img_valid && img_flags[lmtc_pkg::IMG_VM])
		else $error("flags image lacks the virtual flag");

	if_op_trap_a: assert property (op_valid && in_vm && !pg_fault
		&& (op_class == lmtc_pkg::OP_CLI || op_class == lmtc_pkg::OP_STI)
		|=> trap && trap_cause == lmtc_pkg::CS_IFOP && trap_vec == lmtc_pkg::VEC_GP)
		else $error("interrupt flag op not trapped");

	swint_trap_a: assert property (op_valid && in_vm && !pg_fault && op_class == lmtc_pkg::OP_INT
		|=> trap && trap_cause == lmtc_pkg::CS_SWINT)
		else $error("software interrupt not trapped");

	io_trap_a: assert property (op_valid && in_vm && !pg_fault && op_class == lmtc_pkg::OP_IO
		|=> trap == (io_privilege_level != lmtc_pkg::IO_PRIVILEGE_LEVEL_TOP))
		else $error("io trap disagrees with io privilege");

	low_meg_a: assert property (acc_valid && in_vm |=> lin_addr[31:lmtc_pkg::V86_AW] == 12'h000)
		else $error("legacy address above one megabyte");

	page_trap_a: assert property (acc_valid && pg_en && (!pte_present || acc_write && !pte_writable)
		|=> trap && trap_vec == lmtc_pkg::VEC_PF && !lin_valid)
		else $error("page attribute violation not trapped");

	gate_if_a: assert property (enter && !gate_trap |=> !if_q ##1 !if_flag)
		else $error("interrupt gate left interrupts enabled");

	gate_keep_a: assert property (enter && gate_trap |=> if_q == $past(if_q))
		else $error("trap gate changed the interrupt flag");

	fetch_hold_a: assert property ($changed(mode_q) |-> !fetch_ok)
		else $error("fetch allowed in the cycle the mode changed");
endmodule

// ### tb/lmtc_top_bench.sv
// lmtc_top_bench: self-checking bench for the legacy mode trap control block
// assumes one 50 MHz clock; bench drives every bus and core input itself
module lmtc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                     mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic [4:0]               awaddr, araddr;
	logic [31:0]              wdata, rdata, lin_addr;
	logic [3:0]               wstrb, img_flags;
	logic [1:0]               bresp, rresp, task_io_privilege_level, ret_io_privilege_level, io_privilege_level;
	logic                     awready, wready, bvalid, arready, rvalid;
	logic                     task_load, task_vm, task_if, exc_req, intr_req, gate_trap;
	logic                     hret, ret_vm, ret_if, op_valid, acc_valid, acc_write;
	logic                     pte_present, pte_writable, vm_mode, prot_mode, if_flag;
	logic                     fetch_ok, hdl_entry, trap, img_valid, lin_valid;
	logic [15:0]              acc_seg, acc_off;
	logic [7:0]               trap_vec;
	lmtc_pkg::lmtc_op_type    op_class;
	lmtc_pkg::lmtc_cause_type trap_cause;
	int                       bad_count, tests_run, i;
	lmtc_pkg::lmtc_op_type    ops[4] = '{lmtc_pkg::OP_CLI, lmtc_pkg::OP_STI,
		lmtc_pkg::OP_INT, lmtc_pkg::OP_IO};
	lmtc_pkg::lmtc_cause_type causes[4] = '{lmtc_pkg::CS_IFOP, lmtc_pkg::CS_IFOP,
		lmtc_pkg::CS_SWINT, lmtc_pkg::CS_IO};

	lmtc_top lmtc_top_i (.mclk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .task_load, .task_vm, .task_io_privilege_level, .task_if, .exc_req,
		.intr_req, .gate_trap, .hret, .ret_vm, .ret_io_privilege_level, .ret_if, .op_valid, .op_class,
		.acc_valid, .acc_write, .acc_seg, .acc_off, .pte_present, .pte_writable, .vm_mode,
		.prot_mode, .if_flag, .io_privilege_level, .fetch_ok, .hdl_entry, .trap, .trap_vec, .trap_cause,
		.img_valid, .img_flags, .lin_valid, .lin_addr);

	always #10 mclk = ~mclk;

	task tally_and_finish;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// a slave that never answers would hang the run
	task waited(input int n);
		if (n > 40) begin
			bad_count++;
			$display("Error bus answer expected within 40 cycles seen none");
			tally_and_finish();
		end
	endtask

	task axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
			waited(n);
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", bresp, er);
	endtask

	task axr(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			n++;
			waited(n);
		end while (!rvalid);
		rready <= 1'b0;
		chk("rdata", rdata, ed);
		chk("rresp", rresp, er);
	endtask

	// core strobes last exactly one cycle
	task pulse;
		@(posedge mclk);
		{task_load, exc_req, intr_req, hret, op_valid, acc_valid} <= '0;
		#1;
	endtask

	task ld(input logic v, input logic [1:0] pl, input logic f);
		@(posedge mclk);
		{task_load, task_vm, task_io_privilege_level, task_if} <= {1'b1, v, pl, f};
		pulse();
	endtask

	task ret(input logic [1:0] pl);
		@(posedge mclk);
		{hret, ret_vm, ret_io_privilege_level, ret_if} <= {2'b11, pl, 1'b1};
		pulse();
	endtask

	task op(input lmtc_pkg::lmtc_op_type c);
		@(posedge mclk);
		op_valid <= 1'b1;
		op_class <= c;
		pulse();
	endtask

	task acc(input logic w, input logic [15:0] s, input logic [15:0] o, input logic p,
		input logic wr);
		@(posedge mclk);
		{acc_valid, acc_write, acc_seg, acc_off, pte_present, pte_writable} <= {1'b1, w, s, o,
			p, wr};
		pulse();
	endtask

	initial begin
		{mclk, nrst, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{task_load, task_vm, task_io_privilege_level, task_if, exc_req, intr_req, hret, ret_vm} = '0;
		{ret_io_privilege_level, ret_if, op_valid, acc_valid, acc_write, acc_seg, acc_off} = '0;
		{pte_present, pte_writable, bad_count, tests_run} = '0;
		gate_trap = 1'b1;
		wstrb = 4'hf;
		op_class = lmtc_pkg::OP_OTHER;
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk("prot at reset", prot_mode, 0);
		ld(1'b1, 2'h0, 1'b1);
		chk("vm in real", vm_mode, 0);
		axr(lmtc_pkg::OFS_CTRL, 0, lmtc_pkg::RESP_OKAY);
		axr(5'h10, 0, lmtc_pkg::RESP_SLVERR);
		axw(5'h10, 1, lmtc_pkg::RESP_SLVERR);
		axw(lmtc_pkg::OFS_CTRL, 1, lmtc_pkg::RESP_OKAY);
		axr(lmtc_pkg::OFS_CTRL, 1, lmtc_pkg::RESP_OKAY);
		chk("prot on", prot_mode, 1);
		ld(1'b1, 2'h0, 1'b1);
		chk("vm enter", vm_mode, 1);
		chk("fetch hold", fetch_ok, 0);
		for (i = 0; i < 4; i++) begin
			op(ops[i]);
			chk("trap", {trap, trap_vec}, {1'b1, lmtc_pkg::VEC_GP});
			chk("cause", trap_cause, causes[i]);
			chk("vm exit", vm_mode, 0);
			chk("entry", hdl_entry, 1);
			chk("image", {img_valid, img_flags}, 5'h19);
			ret(2'h0);
			chk("vm resume", vm_mode, 1);
		end
		axr(lmtc_pkg::OFS_STAT, 7, lmtc_pkg::RESP_OKAY);
		ld(1'b1, 2'h3, 1'b1);
		op(lmtc_pkg::OP_IO);
		chk("io open", trap, 0);
		op(lmtc_pkg::OP_OTHER);
		chk("plain op", trap, 0);
		@(posedge mclk);
		gate_trap <= 1'b0;
		intr_req <= 1'b1;
		pulse();
		chk("intr exit", vm_mode, 0);
		chk("intr image", {img_valid, img_flags}, 5'h1f);
		@(posedge mclk);
		#1;
		chk("if cleared", if_flag, 0);
		ret(2'h3);
		@(posedge mclk);
		gate_trap <= 1'b1;
		exc_req <= 1'b1;
		pulse();
		chk("exc exit", vm_mode, 0);
		@(posedge mclk);
		#1;
		chk("if kept", if_flag, 1);
		ret(2'h3);
		acc(1'b0, 16'hffff, 16'h0010, 1'b1, 1'b1);
		chk("lin wrap", {lin_valid, lin_addr}, 33'h100000000);
		acc(1'b0, 16'h1234, 16'h5678, 1'b1, 1'b1);
		chk("lin sum", lin_addr, 32'h000179b8);
		axw(lmtc_pkg::OFS_CTRL, 3, lmtc_pkg::RESP_OKAY);
		acc(1'b0, 16'h0100, 16'h0000, 1'b0, 1'b1);
		chk("absent", {trap, trap_vec}, {1'b1, lmtc_pkg::VEC_PF});
		chk("absent cause", trap_cause, lmtc_pkg::CS_PG_NP);
		chk("fetch entry", fetch_ok, 0);
		ret(2'h3);
		acc(1'b1, 16'h0100, 16'h0000, 1'b1, 1'b0);
		chk("ro write", trap_cause, lmtc_pkg::CS_PG_RO);
		ret(2'h3);
		acc(1'b0, 16'h0100, 16'h0000, 1'b1, 1'b0);
		chk("ro read", {trap, lin_valid}, 2'b01);
		ld(1'b0, 2'h0, 1'b1);
		chk("native", {vm_mode, prot_mode}, 2'b01);
		axw(lmtc_pkg::OFS_CTRL, 0, lmtc_pkg::RESP_OKAY);
		@(posedge mclk);
		#1;
		chk("real again", prot_mode, 0);
		tally_and_finish();
	end
endmodule
